/* File: rtl/ict_pkg.sv */
// Shared constants and types for the instruction cycle timing core.
// Assumes a single 25 MHz system clock and a synchronous reset.

package ict_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------
  // Instruction lengths in program bytes
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // ---------------------------------------------------------------
  // Execution times in system clock cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_8 = 4'h8;

  // ---------------------------------------------------------------
  // Counter widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W     = 32;
  localparam logic [7:0]  OP_RST    = 8'h00;
  localparam logic [3:0]  CYC_RST   = 4'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [1:0] ict_len_t;
  typedef logic [3:0] ict_cyc_t;

  typedef struct packed {
    ict_len_t len;
    ict_cyc_t cyc;
    logic     cond;
  } ict_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_EXEC  = 3'h2,
    ST_EXTRA = 3'h4
  } ict_state_t;

endpackage

/* File: rtl/ict_counter.sv */
// Free-running event counter with synchronous clear.
// Assumes the increment comes from logic on the same clock.

`timescale 1ns/1ps

module ict_counter
  import ict_pkg::*;
#(
  parameter int unsigned W = CNT_W
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Event
  input  wire logic         inc,
  // Count
  output logic [W-1:0]      count_q
);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------

  // Wraps silently; software-free core, so no overflow flag
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_q <= '0;
    end
    else if (inc)
    begin
      count_q <= count_q + W'(1);
    end
  end

endmodule

/* File: rtl/ict_timing_core.sv */
// Instruction cycle timing core: decodes each opcode of the classic
// eight-bit accumulator instruction set into its byte length and its
// execution time, then sequences the instruction clock by clock.
// Assumes opcodes arrive from fetch logic on the same clock and that
// the branch outcome is valid in the last base cycle of a branch.
//
// Contract
// RULE1: Execution time is counted in plain clocks, never machine cycles.
// RULE2: Most instructions take as many clocks as they have bytes.
// RULE3: Conditional branch not taken finishes one clock sooner than taken.
// RULE4: Add, add with carry, subtract with borrow from bank register: 1 byte, 1 clock.
// RULE5: Arithmetic on indirect internal RAM: 1 byte, 2 clocks.
// RULE6: Immediate and direct accumulator arithmetic: 2 bytes, 2 clocks.
// RULE7: Logic op immediate into direct byte: 3 bytes, 3 clocks.
// RULE8: Exclusive-or accumulator into direct byte: 2 bytes, 2 clocks.
// RULE9: External data via 8-bit indirect address, read or write: 1 byte, 3 clocks.
// RULE10: External data via data pointer, read or write: 1 byte, 3 clocks.
// RULE11: Code byte fetch relative to PC or data pointer: 1 byte, 3 clocks.
// RULE12: Load data pointer with constant: 3 bytes, 3 clocks.
// RULE13: Direct byte to direct byte move: 3 bytes, 3 clocks.
// RULE14: Store accumulator to indirect RAM: 1 byte, 2 clocks.
// RULE15: Push direct byte: 2 bytes, 2 clocks.
// RULE16: Pop into direct byte: 2 bytes, 2 clocks.
// RULE17: Low nibble exchange with indirect RAM: 1 byte, 2 clocks.
// RULE18: Exchange bank register with accumulator: 1 byte, 1 clock.
// RULE19: Rotate accumulator through carry either way: 1 byte, 1 clock.
// RULE20: Bit ops to carry and direct bit set/clear/complement: 2 bytes, 2 clocks.
// RULE21: Opcode encodings follow the classic instruction set; only timing differs.

`timescale 1ns/1ps

module ict_timing_core
  import ict_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Opcode stream from fetch
  input  wire logic             op_valid,
  input  wire logic [7:0]       op_code,
  output logic                  op_ready,
  // Branch resolution
  input  wire logic             br_taken,
  // Execution status
  output logic                  exec_busy,
  output logic                  exec_fetch,
  output logic [3:0]            exec_cycle_q,
  // Retirement
  output logic                  retire_q,
  output logic [7:0]            retire_opcode_q,
  output logic [1:0]            retire_len_q,
  output logic [3:0]            retire_cycles_q,
  output logic                  retire_taken_q,
  // Statistics
  output logic [CNT_W-1:0]      clock_count_q,
  output logic [CNT_W-1:0]      instr_count_q
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // Entry whose clock count equals its byte count
  function automatic ict_op_t same(input ict_len_t len);
    ict_op_t t;
    t.len  = len;
    t.cyc  = {2'h0, len}; // RULE2
    t.cond = 1'b0;
    return t;
  endfunction

  // Entry with an explicit clock count
  function automatic ict_op_t mk(input ict_len_t len, input ict_cyc_t cyc);
    ict_op_t t;
    t.len  = len;
    t.cyc  = cyc;
    t.cond = 1'b0;
    return t;
  endfunction

  // Conditional branch; cyc is the not-taken time
  function automatic ict_op_t br(input ict_len_t len);
    ict_op_t t;
    t.len  = len;
    t.cyc  = {2'h0, len};
    t.cond = 1'b1; // RULE3
    return t;
  endfunction

  // ---------------------------------------------------------------
  // Opcode table
  // ---------------------------------------------------------------

  // Rows grouped by function, first match wins; register and indirect rows use wildcards
  function automatic ict_op_t decode(input logic [7:0] op);
    ict_op_t t;
    t = same(LEN_1);
    casez (op) // RULE21
      // Branches and jumps
      8'h00: t = same(LEN_1);
      8'b???0_0001: t = mk(LEN_2, CYC_3);
      8'b???1_0001: t = mk(LEN_2, CYC_3);
      8'h02: t = mk(LEN_3, CYC_4);
      8'h12: t = mk(LEN_3, CYC_4);
      8'h22: t = mk(LEN_1, CYC_5);
      8'h32: t = mk(LEN_1, CYC_5);
      8'h73: t = mk(LEN_1, CYC_3);
      8'h80: t = mk(LEN_2, CYC_3);
      8'h10: t = br(LEN_3);
      8'h20: t = br(LEN_3);
      8'h30: t = br(LEN_3);
      8'h40: t = br(LEN_2);
      8'h50: t = br(LEN_2);
      8'h60: t = br(LEN_2);
      8'h70: t = br(LEN_2);
      8'hb4: t = br(LEN_3);
      8'hb5: t = br(LEN_3);
      8'b1011_011?: t = br(LEN_3);
      8'b1011_1???: t = br(LEN_3);
      8'hd5: t = br(LEN_3);
      8'b1101_1???: t = br(LEN_2);
      // Arithmetic, bank register
      8'b0010_1???: t = same(LEN_1); // RULE4
      8'b0011_1???: t = same(LEN_1); // RULE4
      8'b1001_1???: t = same(LEN_1); // RULE4
      8'b0000_1???: t = same(LEN_1);
      8'b0001_1???: t = same(LEN_1);
      // Arithmetic, indirect RAM
      8'b0010_011?: t = mk(LEN_1, CYC_2); // RULE5
      8'b0011_011?: t = mk(LEN_1, CYC_2); // RULE5
      8'b1001_011?: t = mk(LEN_1, CYC_2); // RULE5
      8'b0000_011?: t = mk(LEN_1, CYC_2);
      8'b0001_011?: t = mk(LEN_1, CYC_2);
      // Arithmetic, immediate and direct
      8'h24: t = same(LEN_2); // RULE6
      8'h34: t = same(LEN_2); // RULE6
      8'h94: t = same(LEN_2); // RULE6
      8'h25: t = same(LEN_2); // RULE6
      8'h35: t = same(LEN_2); // RULE6
      8'h95: t = same(LEN_2); // RULE6
      8'h05: t = same(LEN_2);
      8'h15: t = same(LEN_2);
      // Accumulator-only operations
      8'h04: t = same(LEN_1);
      8'h14: t = same(LEN_1);
      8'ha3: t = same(LEN_1);
      8'ha4: t = mk(LEN_1, CYC_4);
      8'h84: t = mk(LEN_1, CYC_8);
      8'hd4: t = same(LEN_1);
      8'he4: t = same(LEN_1);
      8'hf4: t = same(LEN_1);
      8'hc4: t = same(LEN_1);
      8'h03: t = same(LEN_1);
      8'h13: t = same(LEN_1); // RULE19
      8'h23: t = same(LEN_1);
      8'h33: t = same(LEN_1); // RULE19
      8'ha5: t = same(LEN_1);
      // Logical operations into accumulator
      8'b0100_1???: t = same(LEN_1);
      8'b0101_1???: t = same(LEN_1);
      8'b0110_1???: t = same(LEN_1);
      8'b0100_011?: t = mk(LEN_1, CYC_2);
      8'b0101_011?: t = mk(LEN_1, CYC_2);
      8'b0110_011?: t = mk(LEN_1, CYC_2);
      8'h44: t = same(LEN_2);
      8'h54: t = same(LEN_2);
      8'h64: t = same(LEN_2);
      8'h45: t = same(LEN_2);
      8'h55: t = same(LEN_2);
      8'h65: t = same(LEN_2);
      // Logical operations into direct byte
      8'h42: t = same(LEN_2);
      8'h52: t = same(LEN_2);
      8'h62: t = same(LEN_2); // RULE8
      8'h43: t = same(LEN_3); // RULE7
      8'h53: t = same(LEN_3); // RULE7
      8'h63: t = same(LEN_3); // RULE7
      // Data transfer, internal
      8'b1110_1???: t = same(LEN_1);
      8'b1111_1???: t = same(LEN_1);
      8'b0111_1???: t = same(LEN_2);
      8'b1000_1???: t = same(LEN_2);
      8'b1010_1???: t = same(LEN_2);
      8'b1110_011?: t = mk(LEN_1, CYC_2);
      8'b1111_011?: t = mk(LEN_1, CYC_2); // RULE14
      8'b0111_011?: t = same(LEN_2);
      8'b1000_011?: t = same(LEN_2);
      8'b1010_011?: t = same(LEN_2);
      8'h74: t = same(LEN_2);
      8'he5: t = same(LEN_2);
      8'hf5: t = same(LEN_2);
      8'h75: t = same(LEN_3);
      8'h85: t = same(LEN_3); // RULE13
      8'h90: t = same(LEN_3); // RULE12
      // Code and external data moves
      8'h83: t = mk(LEN_1, CYC_3); // RULE11
      8'h93: t = mk(LEN_1, CYC_3); // RULE11
      8'b1110_001?: t = mk(LEN_1, CYC_3); // RULE9
      8'b1111_001?: t = mk(LEN_1, CYC_3); // RULE9
      8'he0: t = mk(LEN_1, CYC_3); // RULE10
      8'hf0: t = mk(LEN_1, CYC_3); // RULE10
      // Stack and exchanges
      8'hc0: t = same(LEN_2); // RULE15
      8'hd0: t = same(LEN_2); // RULE16
      8'b1100_1???: t = same(LEN_1); // RULE18
      8'hc5: t = same(LEN_2);
      8'b1100_011?: t = mk(LEN_1, CYC_2);
      8'b1101_011?: t = mk(LEN_1, CYC_2); // RULE17
      // Boolean manipulation
      8'hb3: t = same(LEN_1);
      8'hc3: t = same(LEN_1);
      8'hd3: t = same(LEN_1);
      8'h82: t = same(LEN_2); // RULE20
      8'hb0: t = same(LEN_2); // RULE20
      8'h72: t = same(LEN_2);
      8'ha0: t = same(LEN_2);
      8'ha2: t = same(LEN_2);
      8'h92: t = same(LEN_2);
      8'hb2: t = same(LEN_2); // RULE20
      8'hc2: t = same(LEN_2); // RULE20
      8'hd2: t = same(LEN_2); // RULE20
      default: t = same(LEN_1);
    endcase
    return t;
  endfunction

  // ---------------------------------------------------------------
  // Control signals
  // ---------------------------------------------------------------

  ict_state_t state_q;
  ict_state_t state_d;
  ict_op_t    dec;
  logic [1:0] len_q;
  logic [3:0] base_q;
  logic       cond_q;
  logic [7:0] opcode_q;
  logic       at_base;
  logic       extend;
  logic       last;
  logic       accept;

  // Table lookup on the opcode presented this cycle
  assign dec = decode(op_code);

  // Final base clock reached
  assign at_base = (state_q == ST_EXEC) && (exec_cycle_q == base_q);

  // Taken conditional branch buys exactly one more clock
  assign extend = at_base && cond_q && br_taken; // RULE3

  // Last clock of the running instruction
  assign last = (at_base && !extend) || (state_q == ST_EXTRA);

  // Ready in idle or in the last clock, so instructions run back to back
  assign op_ready = (state_q == ST_IDLE) || last;
  assign accept   = op_valid && op_ready;

  // Status views
  assign exec_busy  = (state_q != ST_IDLE);
  assign exec_fetch = (state_q == ST_EXEC) && (exec_cycle_q <= {2'h0, len_q}); // RULE2

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        if (extend)
        begin
          state_d = ST_EXTRA; // RULE3
        end
        else if (at_base)
        begin
          state_d = accept ? ST_EXEC : ST_IDLE;
        end
      end
      ST_EXTRA:
      begin
        state_d = accept ? ST_EXEC : ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Clock index within the instruction; one step per clock, no grouping
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      exec_cycle_q <= CYC_RST;
    end
    else if (accept)
    begin
      exec_cycle_q <= CYC_1; // RULE1
    end
    else if (exec_busy && !last)
    begin
      exec_cycle_q <= exec_cycle_q + 4'h1; // RULE1
    end
    else
    begin
      exec_cycle_q <= CYC_RST;
    end
  end

  // Latch the decoded timing when the opcode is taken
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      len_q    <= LEN_1;
      base_q   <= CYC_1;
      cond_q   <= 1'b0;
      opcode_q <= OP_RST;
    end
    else if (accept)
    begin
      len_q    <= dec.len;
      base_q   <= dec.cyc;
      cond_q   <= dec.cond;
      opcode_q <= op_code;
    end
  end

  // ---------------------------------------------------------------
  // Retirement report
  // ---------------------------------------------------------------

  // One-clock pulse after the last clock; fields hold until next retire
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      retire_q        <= 1'b0;
      retire_opcode_q <= OP_RST;
      retire_len_q    <= LEN_1;
      retire_cycles_q <= CYC_RST;
      retire_taken_q  <= 1'b0;
    end
    else
    begin
      retire_q <= last;
      if (last)
      begin
        retire_opcode_q <= opcode_q;
        retire_len_q    <= len_q;
        retire_cycles_q <= exec_cycle_q;
        retire_taken_q  <= (state_q == ST_EXTRA); // RULE3
      end
    end
  end

  // ---------------------------------------------------------------
  // Statistics
  // ---------------------------------------------------------------

  // Busy clocks; plain clock units so totals match the table directly
  ict_counter #(.W(CNT_W)) u_clock_cnt
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .inc     (exec_busy),
    .count_q (clock_count_q)
  );

  // Completed instructions
  ict_counter #(.W(CNT_W)) u_instr_cnt
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .inc     (last),
    .count_q (instr_count_q)
  );

endmodule

/* File: sim/ict_timing_chk.sv */
// Checker for the instruction cycle timing core, sees only its ports.
// Assumes one clock domain and the synchronous active-high reset.

`timescale 1ns/1ps

module ict_timing_chk
  import ict_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             sys_rst,
  // Opcode stream and branch
  input wire logic             op_valid,
  input wire logic [7:0]       op_code,
  input wire logic             op_ready,
  input wire logic             br_taken,
  // Status and retirement
  input wire logic             exec_busy,
  input wire logic             exec_fetch,
  input wire logic [3:0]       exec_cycle_q,
  input wire logic             retire_q,
  input wire logic [7:0]       retire_opcode_q,
  input wire logic [1:0]       retire_len_q,
  input wire logic [3:0]       retire_cycles_q,
  input wire logic             retire_taken_q,
  input wire logic [CNT_W-1:0] clock_count_q,
  input wire logic [CNT_W-1:0] instr_count_q
);
  // ---------------------------------------------------------------
  // Timing properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Opcode accepted at this edge
  logic take;
  assign take = op_valid && op_ready;

  cycle_step_a: assert property (exec_busy && !op_ready |=> exec_cycle_q == $past(exec_cycle_q) + 4'h1)
    else $error("clock index did not step by one");
  take_start_a: assert property (take |=> exec_busy && exec_cycle_q == 4'h1)
    else $error("accepted opcode did not start at clock one");
  clock_count_a: assert property (exec_busy |=> clock_count_q == $past(clock_count_q) + 32'h1)
    else $error("busy clock not counted");
  retire_count_a: assert property (exec_busy && op_ready |=> retire_q && retire_cycles_q == $past(exec_cycle_q))
    else $error("retire missing or wrong clock count");
  single_clock_a: assert property (take && op_code inside {8'h28, 8'h3b, 8'h9f} |=> op_ready)
    else $error("register arithmetic took more than one clock");
  indirect_ram_a: assert property (take && op_code inside {8'h26, 8'h97, 8'hf6, 8'hd7} |=> !op_ready ##1 op_ready)
    else $error("indirect access not two clocks");
  ext_code_a: assert property (take && op_code inside {8'he2, 8'hf3, 8'he0, 8'hf0, 8'h83, 8'h93} |=> !op_ready [*2] ##1 op_ready ##1 retire_len_q == 2'h1)
    else $error("external or code move not three clocks");
  three_byte_a: assert property (take && op_code inside {8'h53, 8'h43, 8'h63, 8'h90, 8'h85} |=> !op_ready [*2] ##1 op_ready ##1 retire_len_q == 2'h3)
    else $error("three byte op not three clocks");
  two_byte_a: assert property (take && op_code inside {8'h94, 8'h25, 8'h34, 8'h62, 8'hc0, 8'hd0, 8'h82, 8'hd2, 8'hc2, 8'hb2} |=> !op_ready ##1 op_ready ##1 retire_len_q == 2'h2)
    else $error("two byte op not two clocks");
  exch_rotate_a: assert property (take && op_code inside {8'hca, 8'h13, 8'h33} |=> op_ready ##1 retire_q && retire_cycles_q == 4'h1)
    else $error("exchange or rotate not one clock");
  branch_time_a: assert property (retire_q && retire_opcode_q inside {8'h40, 8'h20, 8'hd8, 8'hb4} |-> retire_cycles_q == {2'h0, retire_len_q} + {3'h0, retire_taken_q})
    else $error("branch time not length plus outcome");
  fetch_span_a: assert property (take && op_code == 8'h83 |=> exec_fetch ##1 !exec_fetch [*2])
    else $error("byte window does not match one byte length");

  // Main scenarios seen
  cover property (take && exec_busy);
  cover property (retire_q && retire_taken_q);
  cover property (op_valid && !op_ready);
endmodule

bind ict_timing_core ict_timing_chk i_ict_timing_chk (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_ready(op_ready), .br_taken(br_taken), .exec_busy(exec_busy), .exec_fetch(exec_fetch),
  .exec_cycle_q(exec_cycle_q), .retire_q(retire_q), .retire_opcode_q(retire_opcode_q),
  .retire_len_q(retire_len_q), .retire_cycles_q(retire_cycles_q), .retire_taken_q(retire_taken_q),
  .clock_count_q(clock_count_q), .instr_count_q(instr_count_q));

/* File: sim/ict_fetch_model.sv */
// Program memory model: offers opcodes with random gaps, holds them until taken.
// Assumes the bench loads rom_op, rom_tkn, rom_gap and n_ops before reset ends.

`timescale 1ns/1ps

module ict_fetch_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Opcode handshake
  input  wire logic op_ready,
  output logic      op_valid,
  output logic [7:0] op_code,
  // Branch outcome
  output logic      br_taken
);
  logic [7:0] rom_op  [128];
  logic       rom_tkn [128];
  logic [1:0] rom_gap [128];
  int         n_ops = 0;
  int         pc;
  int         gap;

  // Offer, hold until taken; scramble the byte while idle so stale data never looks valid
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pc = 0;
      gap = 0;
      op_valid <= 1'b0;
      op_code  <= 8'h5a;
      br_taken <= 1'b0;
    end
    else
    begin
      if (op_valid && op_ready)
      begin
        br_taken <= rom_tkn[pc];
        pc = pc + 1;
        gap = (pc < 128) ? int'(rom_gap[pc]) : 0;
      end
      if (gap > 0 || pc >= n_ops)
      begin
        op_valid <= 1'b0;
        op_code  <= ~op_code;
        gap = (gap > 0) ? gap - 1 : 0;
      end
      else
      begin
        op_valid <= 1'b1;
        op_code  <= rom_op[pc];
      end
    end
  end
endmodule

/* File: sim/cpu_instruction_cycle_timing_test.sv */
// Self-checking bench for the timing core with a program memory model.
// Assumes the checker is bound to the core by its own file.

`timescale 1ns/1ps

module cpu_instruction_cycle_timing_test;
  import ict_pkg::*;
  localparam int N_OPS = 37;
  localparam int N_SEQ = 120;
  // Entry: opcode, bytes, clocks, conditional
  localparam logic [14:0] OPS [N_OPS] = '{
    {8'h28, 6'h11, 1'b0}, {8'h3b, 6'h11, 1'b0}, {8'h9f, 6'h11, 1'b0},
    {8'h26, 6'h12, 1'b0}, {8'h97, 6'h12, 1'b0},
    {8'h94, 6'h22, 1'b0}, {8'h25, 6'h22, 1'b0}, {8'h34, 6'h22, 1'b0},
    {8'h53, 6'h33, 1'b0}, {8'h43, 6'h33, 1'b0}, {8'h63, 6'h33, 1'b0}, {8'h62, 6'h22, 1'b0},
    {8'he2, 6'h13, 1'b0}, {8'hf3, 6'h13, 1'b0}, {8'he0, 6'h13, 1'b0}, {8'hf0, 6'h13, 1'b0},
    {8'h83, 6'h13, 1'b0}, {8'h93, 6'h13, 1'b0}, {8'h90, 6'h33, 1'b0}, {8'h85, 6'h33, 1'b0},
    {8'hf6, 6'h12, 1'b0}, {8'hc0, 6'h22, 1'b0}, {8'hd0, 6'h22, 1'b0}, {8'hd7, 6'h12, 1'b0},
    {8'hca, 6'h11, 1'b0}, {8'h13, 6'h11, 1'b0}, {8'h33, 6'h11, 1'b0},
    {8'h82, 6'h22, 1'b0}, {8'hd2, 6'h22, 1'b0}, {8'hc2, 6'h22, 1'b0}, {8'hb2, 6'h22, 1'b0},
    {8'h40, 6'h22, 1'b1}, {8'h20, 6'h33, 1'b1}, {8'h00, 6'h11, 1'b0}, {8'ha5, 6'h11, 1'b0},
    {8'hd8, 6'h22, 1'b1}, {8'hb4, 6'h33, 1'b1}};

  logic             clk;
  logic             sys_rst;
  logic             op_valid;
  logic [7:0]       op_code;
  logic             op_ready;
  logic             br_taken;
  logic             retire_q;
  logic [7:0]       retire_opcode_q;
  logic [1:0]       retire_len_q;
  logic [3:0]       retire_cycles_q;
  logic             retire_taken_q;
  logic [CNT_W-1:0] clock_count_q;
  logic [CNT_W-1:0] instr_count_q;
  logic [14:0]      exp_q [$];
  logic [14:0]      want;
  int               n_mismatch = 0;
  int               checked = 0;
  int               exp_clk = 0;
  integer           seed = 26204;

  ict_timing_core i_ict_timing_core (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .op_ready(op_ready), .br_taken(br_taken), .exec_busy(), .exec_fetch(), .exec_cycle_q(), .retire_q(retire_q),
    .retire_opcode_q(retire_opcode_q), .retire_len_q(retire_len_q), .retire_cycles_q(retire_cycles_q),
    .retire_taken_q(retire_taken_q), .clock_count_q(clock_count_q), .instr_count_q(instr_count_q));

  ict_fetch_model i_ict_fetch_model (.clk(clk), .sys_rst(sys_rst), .op_ready(op_ready), .op_valid(op_valid),
    .op_code(op_code), .br_taken(br_taken));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // Retire watcher: oldest note against each retirement
  always @(posedge clk)
  begin
    if (!sys_rst && retire_q === 1'b1)
    begin
      want = (exp_q.size() != 0) ? exp_q.pop_front() : 15'h7fff;
      check({49'h0, retire_opcode_q, retire_len_q, retire_cycles_q, retire_taken_q}, {49'h0, want});
    end
  end

  // Watchdog, well past the longest expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

  // ---------------------------------------------------------------
  // Main sequence: table twice (not taken, taken), then random picks
  // ---------------------------------------------------------------
  initial
  begin
    int          k;
    int          e;
    logic        tk;
    logic [31:0] r;
    sys_rst = 1'b1;
    for (k = 0; k < N_SEQ; k++)
    begin
      r = $random(seed);
      e = (k < 2 * N_OPS) ? k % N_OPS : int'(r[30:8] % N_OPS);
      tk = (k < 2 * N_OPS) ? (k >= N_OPS) : r[0];
      i_ict_fetch_model.rom_op[k] = OPS[e][14:7];
      i_ict_fetch_model.rom_tkn[k] = tk;
      i_ict_fetch_model.rom_gap[k] = r[3] ? r[2:1] : 2'h0;
      tk = tk & OPS[e][0];
      exp_q.push_back({OPS[e][14:5], OPS[e][4:1] + {3'h0, tk}, tk});
      exp_clk += int'(OPS[e][4:1]) + int'(tk);
    end
    i_ict_fetch_model.n_ops = N_SEQ;
    repeat (3) @(posedge clk);
    check({56'h0, op_ready, retire_q, retire_len_q, retire_cycles_q}, {56'h0, 1'b1, 1'b0, 2'h1, 4'h0});
    check({instr_count_q, clock_count_q}, 64'h0);
    sys_rst <= 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    check(64'(exp_q.size()), 64'h0);
    check({instr_count_q, clock_count_q}, {N_SEQ[31:0], exp_clk[31:0]});
    finish_test;
  end
endmodule
